/* File: bench/sigmix_chk.sv */
// port checker for the signal mixer
`timescale 1ns/1ns
`include "sigmix_defines.svh"

module sigmix_chk #(
   parameter int N_MOD_SRC = 32,
   parameter int N_CAR_SRC = 16,
   parameter int SYNC_STAGES = 2
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic [`SIGMIX_ADDR_W-1:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic [N_MOD_SRC-1:0] modulator_periph_in,
   input wire logic [N_CAR_SRC-1:0] carrier_periph_in,
   input wire logic modulator_pin_in,
   input wire logic carrier_high_pin_in,
   input wire logic carrier_low_pin_in,
   input wire logic mixer_output_pin_out
);
   logic [7:0] c0, c1, src, csl, csh;
   logic [4:0] mh, hh;
   logic modv, ch, cl;

   // raw selected sources, as software configured them
   assign modv = (src == 8'h1f) ? c0[0] : (src == 8'h00) ? modulator_pin_in :
      modulator_periph_in[src[4:0]];
   assign ch = (csh == 8'h00) ? carrier_high_pin_in : carrier_periph_in[csh[3:0]];
   assign cl = (csl == 8'h00) ? carrier_low_pin_in : carrier_periph_in[csl[3:0]];

   // shadow of the writable bits plus short source histories
   always_ff @(posedge clk_in) begin
      mh <= {mh[3:0], modv};
      hh <= {hh[3:0], ch};
      if (srst_in) begin
         c0 <= 8'h00;
         c1 <= 8'h00;
         src <= 8'h00;
         csl <= 8'h00;
         csh <= 8'h00;
      end else if (reg_wr_in) begin
         if (reg_addr_in == `SIGMIX_OFS_CONTROL_0) c0 <= reg_wdata_in & 8'h91;
         if (reg_addr_in == `SIGMIX_OFS_CONTROL_1) c1 <= reg_wdata_in & 8'h33;
         if (reg_addr_in == `SIGMIX_OFS_SOURCE) src <= reg_wdata_in & 8'h1f;
         if (reg_addr_in == `SIGMIX_OFS_CARRIER_LOW) csl <= reg_wdata_in & 8'h0f;
         if (reg_addr_in == `SIGMIX_OFS_CARRIER_HIGH) csh <= reg_wdata_in & 8'h0f;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   // ***********
   // assertions
   // ***********
   a_reset_quiet: assert property ($fell(srst_in) |-> reg_rdata_out == 8'h00 &&
      !mixer_output_pin_out) else $error("state not cleared by reset");
   a_out_gated: assert property (!c0[7] |-> !mixer_output_pin_out)
      else $error("output high while disabled");
   a_mix_high: assert property (c0[7] && !c1[4] && !c1[0] && modv |->
      mixer_output_pin_out == (ch ^ c1[5] ^ c0[4])) else $error("high carrier mix wrong");
   a_mix_low: assert property (c0[7] && !c1[4] && !c1[0] && !modv |->
      mixer_output_pin_out == (cl ^ c1[1] ^ c0[4])) else $error("low carrier mix wrong");
   a_idle_high: assert property (c0[7] && c0[4] && c1[1:0] == 2'b00 && !modv
      && cl == c1[1] |-> mixer_output_pin_out) else $error("inverted idle not high");
   a_status_bit: assert property (reg_rd_in && reg_addr_in == `SIGMIX_OFS_CONTROL_0
      |=> reg_rdata_out == (c0 | {2'b00, $past(mixer_output_pin_out), 5'h00}))
      else $error("control 0 read wrong");
   a_select_kept: assert property (reg_rd_in && reg_addr_in == `SIGMIX_OFS_SOURCE
      |=> reg_rdata_out == src) else $error("source select read wrong");
   a_sync_hold: assert property (c0[7] && c1[4] && !c1[5] && !c0[4] && &mh && &hh
      && ch && !modv |-> mixer_output_pin_out) else $error("high carrier pulse cut");
endmodule : sigmix_chk

/* File: bench/sigmix_src_model.sv */
// stand-in for the peripherals and pins that feed the signal mixer
`timescale 1ns/1ns

module sigmix_src_model (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic mod_level_in,
   output logic [31:0] modulator_periph_out,
   output logic [15:0] carrier_periph_out,
   output logic modulator_pin_out,
   output logic carrier_high_pin_out,
   output logic carrier_low_pin_out
);
   logic [7:0] cnt;

   // free-running divider, carrier codes sharing their two low bits see the same rate
   always_ff @(posedge clk_in) begin
      cnt <= srst_in ? 8'h00 : cnt + 8'h01;
   end

   // odd modulator codes inverted so a wrong select shows up
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         modulator_periph_out[i] = mod_level_in ^ i[0];
      end
      for (int k = 0; k < 16; k++) begin
         carrier_periph_out[k] = cnt[k[1:0]] ^ k[3];
      end
      modulator_pin_out = mod_level_in;
      carrier_high_pin_out = cnt[0];
      carrier_low_pin_out = ~cnt[1];
   end
endmodule : sigmix_src_model

/* File: bench/sigmix_tb_top.sv */
// self-checking bench for the signal mixer
`timescale 1ns/1ns
`include "sigmix_defines.svh"

module sigmix_tb_top;
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic [11:0] reg_addr_in = 12'h000;
   logic [7:0] reg_wdata_in = 8'h00;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [7:0] reg_rdata_out;
   logic [31:0] modulator_periph_in;
   logic [15:0] carrier_periph_in;
   logic modulator_pin_in, carrier_high_pin_in, carrier_low_pin_in, mixer_output_pin_out;
   logic mod_lv = 1'b0;
   int failures = 0;
   int n_tests = 0;
   logic [7:0] t_reg [5];
   logic [7:0] msk [5] = '{8'h91, 8'h33, 8'h1f, 8'h0f, 8'h0f};
   logic [7:0] q;
   logic st;

   always #25 clk_in = ~clk_in;

   sigmix_src_model sigmix_src_model_i (.clk_in, .srst_in, .mod_level_in(mod_lv),
      .modulator_periph_out(modulator_periph_in), .carrier_periph_out(carrier_periph_in),
      .modulator_pin_out(modulator_pin_in), .carrier_high_pin_out(carrier_high_pin_in),
      .carrier_low_pin_out(carrier_low_pin_in));
   sigmix_top sigmix_top_i (.clk_in, .srst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
      .reg_rd_in, .reg_rdata_out, .modulator_periph_in, .carrier_periph_in, .modulator_pin_in,
      .carrier_high_pin_in, .carrier_low_pin_in, .mixer_output_pin_out);

   // *******************
   // expectation model
   // *******************
   function automatic logic sel(input logic [7:0] code, input logic pin);
      return (code == 8'h00) ? pin : carrier_periph_in[code[3:0]];
   endfunction : sel

   function automatic logic exp_out();
      logic m;
      m = (t_reg[2] == 8'h1f) ? t_reg[0][0] : (t_reg[2] == 8'h00) ? modulator_pin_in :
         modulator_periph_in[t_reg[2][4:0]];
      m = m ? sel(t_reg[4], carrier_high_pin_in) ^ t_reg[1][5] :
         sel(t_reg[3], carrier_low_pin_in) ^ t_reg[1][1];
      return t_reg[0][7] & (m ^ t_reg[0][4]);
   endfunction : exp_out

   // *******************
   // bus and check tasks
   // *******************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // ends on a spare edge so the next strobe is never set twice in one step
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
      if (a >= `SIGMIX_OFS_CONTROL_0 && a <= `SIGMIX_OFS_CARRIER_HIGH) begin
         t_reg[a - `SIGMIX_OFS_CONTROL_0] = d & msk[a - `SIGMIX_OFS_CONTROL_0];
      end
      @(posedge clk_in);
   endtask : wr

   // expected status level is taken just before the read edge
   task automatic rd(input logic [11:0] a);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(negedge clk_in);
      st = exp_out();
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      @(negedge clk_in);
      q = reg_rdata_out;
      @(posedge clk_in);
   endtask : rd

   task automatic rdchk(input int i);
      rd(`SIGMIX_OFS_CONTROL_0 + 12'(i));
      chk(q, t_reg[i] | ((i == 0) ? {2'b00, st, 5'h00} : 8'h00));
   endtask : rdchk

   task automatic watch(input int n);
      repeat (n) begin
         @(negedge clk_in);
         chk({7'h00, mixer_output_pin_out}, {7'h00, exp_out()});
         @(posedge clk_in);
         mod_lv <= ~mod_lv;
      end
   endtask : watch

   task automatic wait_car(input logic v);
      int k;
      k = 0;
      do begin
         @(negedge clk_in);
         k++;
      end while (carrier_periph_in[3] !== v && k < 40);
      if (k >= 40) failures++;
   endtask : wait_car

   // modulator flips five cycles into a carrier pulse; sync decides if it survives
   task automatic sy(input logic dir, input logic [7:0] cv);
      wr(`SIGMIX_OFS_CONTROL_1, cv | 8'h02);
      mod_lv <= dir;
      repeat (12) @(posedge clk_in);
      wait_car(~dir);
      wait_car(dir);
      repeat (5) @(posedge clk_in);
      mod_lv <= ~dir;
      @(negedge clk_in);
      chk({7'h00, mixer_output_pin_out}, {7'h00, dir ? cv[4] : cv[0]});
      @(posedge clk_in);
   endtask : sy

   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up

   // ******
   // tests
   // ******
   initial begin
      static logic [7:0] modulator_source_select [4] = '{8'h00, 8'h01, 8'h02, 8'h1f};
      static logic [7:0] cars [3] = '{8'h00, 8'h03, 8'h09};
      static logic [7:0] pols [4] = '{8'h00, 8'h20, 8'h02, 8'h22};
      static logic [7:0] ens [3] = '{8'h80, 8'h10, 8'h91};
      t_reg = '{default: 8'h00};
      repeat (20) @(posedge clk_in);
      srst_in <= 1'b0;
      @(posedge clk_in);
      for (int i = 0; i < 5; i++) rdchk(i);
      for (int i = 0; i < 5; i++) begin
         wr(`SIGMIX_OFS_CONTROL_0 + 12'(i), 8'hff);
         rdchk(i);
      end
      wr(12'hf51, 8'hff);
      rd(12'hf51);
      chk(q, 8'h00);
      $display("registers test done");
      // disable and re-enable inside each selection set, never reconfiguring
      for (int m = 0; m < 4; m++) begin
         for (int c = 0; c < 3; c++) begin
            for (int p = 0; p < 4; p++) begin
               wr(`SIGMIX_OFS_SOURCE, modulator_source_select[m]);
               wr(`SIGMIX_OFS_CARRIER_HIGH, cars[c]);
               wr(`SIGMIX_OFS_CARRIER_LOW, 8'h09 - cars[c]);
               wr(`SIGMIX_OFS_CONTROL_1, pols[p]);
               for (int e = 0; e < 3; e++) begin
                  wr(`SIGMIX_OFS_CONTROL_0, ens[e]);
                  watch(6);
                  rdchk(0);
               end
               rdchk(2);
            end
         end
      end
      $display("mixing test done");
      wr(`SIGMIX_OFS_SOURCE, 8'h00);
      wr(`SIGMIX_OFS_CARRIER_HIGH, 8'h03);
      wr(`SIGMIX_OFS_CARRIER_LOW, 8'h03);
      wr(`SIGMIX_OFS_CONTROL_0, 8'h80);
      for (int d = 0; d < 2; d++) begin
         for (int s = 0; s < 4; s++) sy(d[0], {3'b000, s[1], 3'b000, s[0]});
      end
      $display("sync test done");
      srst_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      srst_in <= 1'b0;
      t_reg = '{default: 8'h00};
      @(posedge clk_in);
      for (int i = 0; i < 5; i++) rdchk(i);
      @(negedge clk_in);
      chk({7'h00, mixer_output_pin_out}, 8'h00);
      $display("second reset test done");
      wrap_up();
   end

   // watchdog, about seven times the expected run
   initial begin
      repeat (15000) @(posedge clk_in);
      failures++;
      wrap_up();
   end
endmodule : sigmix_tb_top

bind sigmix_top sigmix_chk #(.N_MOD_SRC(N_MOD_SRC), .N_CAR_SRC(N_CAR_SRC),
   .SYNC_STAGES(SYNC_STAGES)) sigmix_chk_i (.clk_in, .srst_in, .reg_addr_in, .reg_wdata_in,
   .reg_wr_in, .reg_rd_in, .reg_rdata_out, .modulator_periph_in, .carrier_periph_in,
   .modulator_pin_in, .carrier_high_pin_in, .carrier_low_pin_in, .mixer_output_pin_out);

/* File: common/sigmix_defines.svh */
// offsets, field positions, reset values and widths of the signal mixer
`ifndef SIGMIX_DEFINES_SVH
`define SIGMIX_DEFINES_SVH

// ***************************************************
// register offsets (byte addresses on the plain port)
// ***************************************************
`define SIGMIX_ADDR_W 12
`define SIGMIX_OFS_CONTROL_0 12'hf4c
`define SIGMIX_OFS_CONTROL_1 12'hf4d
`define SIGMIX_OFS_SOURCE 12'hf4e
`define SIGMIX_OFS_CARRIER_LOW 12'hf4f
`define SIGMIX_OFS_CARRIER_HIGH 12'hf50

// ***************************************************
// field positions
// ***************************************************
`define SIGMIX_C0_ENABLE 7
`define SIGMIX_C0_OUT 5
`define SIGMIX_C0_OUTPUT_INVERT 4
`define SIGMIX_C0_SW_BIT 0
`define SIGMIX_C1_HIGH_INVERT 5
`define SIGMIX_C1_HIGH_SYNC 4
`define SIGMIX_C1_LOW_INVERT 1
`define SIGMIX_C1_LOW_SYNC 0

// ***************************************************
// widths, source codes and reset values
// ***************************************************
`define SIGMIX_MOD_SEL_W 5
`define SIGMIX_CAR_SEL_W 4
`define SIGMIX_SRC_PIN 5'h00
`define SIGMIX_SRC_SW_BIT 5'h1f
`define SIGMIX_CAR_PIN 4'h0
`define SIGMIX_RST_BYTE 8'h00
`define SIGMIX_RST_MOD_SEL 5'h00
`define SIGMIX_RST_CAR_SEL 4'h0

`endif

/* File: common/sigmix_pkg.sv */
// types shared by the signal mixer modules
`include "sigmix_defines.svh"
package sigmix_pkg;

   // which carrier is feeding the output, one-hot
   typedef enum logic [1:0] {
      SIDE_LOW = 2'b01,
      SIDE_HIGH = 2'b10
   } sigmix_side_e;

   typedef logic [`SIGMIX_MOD_SEL_W-1:0] sigmix_mod_sel_t;
   typedef logic [`SIGMIX_CAR_SEL_W-1:0] sigmix_car_sel_t;

   // every flip-flop of the mixer top
   typedef struct packed {
      logic enable;
      logic output_invert;
      logic sw_bit;
      logic high_invert;
      logic high_sync;
      logic low_invert;
      logic low_sync;
      sigmix_mod_sel_t mod_sel;
      sigmix_car_sel_t low_sel;
      sigmix_car_sel_t high_sel;
      sigmix_side_e side;
      logic [7:0] rdata;
   } sigmix_state_s;

endpackage : sigmix_pkg

/* File: hdl/sigmix_sync.sv */
// multi-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/1ns

module sigmix_sync #(
   parameter int WIDTH = 8,
   parameter int STAGES = 2
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // ***************************************************
   // elaboration checks
   // ***************************************************
   if (STAGES < 2 || WIDTH < 1) begin : g_bad_params
      $error("sigmix_sync needs at least two stages and one bit");
   end

   typedef struct packed {
      logic [STAGES-1:0][WIDTH-1:0] chain;
   } sigmix_sync_s;

   sigmix_sync_s state;
   sigmix_sync_s next_state;

   // ***************************************************
   // shift chain
   // ***************************************************
   // stage 0 is read only by stage 1, never by logic
   always_comb begin
      next_state = state;
      next_state.chain[0] = async_in;
      for (int i = 1; i < STAGES; i++) begin
         next_state.chain[i] = state.chain[i-1];
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign sync_out = state.chain[STAGES-1];

endmodule : sigmix_sync

/* File: hdl/sigmix_top.sv */
// signal mixer: modulator stream gated onto two selectable carriers
`timescale 1ns/1ns
`include "sigmix_defines.svh"

module sigmix_top #(
   parameter int N_MOD_SRC = 32,
   parameter int N_CAR_SRC = 16,
   parameter int SYNC_STAGES = 2
) (
   input wire logic clk_in,
   input wire logic srst_in,
   // register port
   input wire logic [`SIGMIX_ADDR_W-1:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // candidate sources; index 0 of each vector is unused (pin code)
   input wire logic [N_MOD_SRC-1:0] modulator_periph_in,
   input wire logic [N_CAR_SRC-1:0] carrier_periph_in,
   input wire logic modulator_pin_in,
   input wire logic carrier_high_pin_in,
   input wire logic carrier_low_pin_in,
   // toward the pin routing logic
   output logic mixer_output_pin_out
);

   // ***************************************************
   // elaboration checks
   // ***************************************************
   if (N_MOD_SRC != (1 << `SIGMIX_MOD_SEL_W)) begin : g_bad_mod
      $error("sigmix_top: N_MOD_SRC must match the modulator select width");
   end
   if (N_CAR_SRC != (1 << `SIGMIX_CAR_SEL_W)) begin : g_bad_car
      $error("sigmix_top: N_CAR_SRC must match the carrier select width");
   end

   // ***************************************************
   // helpers
   // ***************************************************
   // modulator pick: pin, software bit or peripheral
   function automatic logic pick_mod(
      input logic [N_MOD_SRC-1:0] periph,
      input logic pin,
      input logic sw,
      input sigmix_pkg::sigmix_mod_sel_t sel
   );
      logic r;
      r = periph[sel];
      if (sel == `SIGMIX_SRC_PIN) begin
         r = pin;
      end else if (sel == `SIGMIX_SRC_SW_BIT) begin
         r = sw;
      end
      return r;
   endfunction : pick_mod

   // carrier pick with optional inversion
   function automatic logic pick_car(
      input logic [N_CAR_SRC-1:0] periph,
      input logic pin,
      input sigmix_pkg::sigmix_car_sel_t sel,
      input logic invert
   );
      logic r;
      r = periph[sel];
      if (sel == `SIGMIX_CAR_PIN) begin
         r = pin;
      end
      return r ^ invert;
   endfunction : pick_car

   // ***************************************************
   // state
   // ***************************************************
   sigmix_pkg::sigmix_state_s state;
   sigmix_pkg::sigmix_state_s next_state;

   logic [N_MOD_SRC-1:0] mod_periph_s;
   logic [N_CAR_SRC-1:0] car_periph_s;
   logic [2:0] pins_s;
   logic mod_raw;
   logic high_raw;
   logic low_raw;
   logic mod_s;
   logic high_s;
   logic low_s;
   logic holding;
   logic bridging;
   logic keep_side;
   logic use_high;
   logic mixed;
   logic out_level;
   logic [7:0] control_0_rd;
   logic [7:0] control_1_rd;

   // ***************************************************
   // synchronised copies for the switch-over logic
   // ***************************************************
   // only the hold decision needs clean levels; the gating path
   // below reads the raw sources so fast carriers pass through
   sigmix_sync #(
      .WIDTH(N_MOD_SRC + N_CAR_SRC + 3),
      .STAGES(SYNC_STAGES)
   ) u_sync (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .async_in({modulator_periph_in, carrier_periph_in,
                 modulator_pin_in, carrier_high_pin_in, carrier_low_pin_in}),
      .sync_out({mod_periph_s, car_periph_s, pins_s})
   );

   // ***************************************************
   // source selection, raw and synchronised
   // ***************************************************
   // raw picks feed the output, synced picks feed the hold logic
   always_comb begin
      mod_raw = pick_mod(modulator_periph_in, modulator_pin_in,
                         state.sw_bit, state.mod_sel);
      high_raw = pick_car(carrier_periph_in, carrier_high_pin_in,
                          state.high_sel, state.high_invert);
      low_raw = pick_car(carrier_periph_in, carrier_low_pin_in,
                         state.low_sel, state.low_invert);
      mod_s = pick_mod(mod_periph_s, pins_s[2], state.sw_bit, state.mod_sel);
      high_s = pick_car(car_periph_s, pins_s[1], state.high_sel, state.high_invert);
      low_s = pick_car(car_periph_s, pins_s[0], state.low_sel, state.low_invert);
   end

   // ***************************************************
   // carrier hand-over
   // ***************************************************
   // holding: the modulator has moved away from the side in use,
   // sync is on for that side and its carrier pulse is still high;
   // bridging covers the synchroniser delay, while the raw modulator
   // has moved but its synced copy has not, so the pulse is never cut
   always_comb begin
      holding = 1'b0;
      bridging = 1'b0;
      if (state.side == sigmix_pkg::SIDE_HIGH) begin
         holding = !mod_s && state.high_sync && high_s;
         bridging = mod_s && !mod_raw && state.high_sync && high_raw;
      end else begin
         holding = mod_s && state.low_sync && low_s;
         bridging = !mod_s && mod_raw && state.low_sync && low_raw;
      end
      keep_side = holding || bridging;
   end

   // while no hold is pending the raw modulator steers directly,
   // so unsynchronised switching costs no latency
   always_comb begin
      use_high = mod_raw;
      if (keep_side) begin
         use_high = (state.side == sigmix_pkg::SIDE_HIGH);
      end
   end

   // ***************************************************
   // output gating
   // ***************************************************
   // the and-form keeps the carrier gated by the modulator level;
   // a held pulse is passed with its own carrier only
   always_comb begin
      if (use_high) begin
         mixed = high_raw & (mod_raw | keep_side);
      end else begin
         mixed = low_raw & (!mod_raw | keep_side);
      end
   end

   // disabled output is low whatever the invert bit says
   assign out_level = state.enable ? (mixed ^ state.output_invert) : 1'b0;
   assign mixer_output_pin_out = out_level;

   // ***************************************************
   // read views
   // ***************************************************
   // status bit shows the level as seen through the side logic;
   // very fast carriers may read stale, a known limitation
   always_comb begin
      control_0_rd = `SIGMIX_RST_BYTE;
      control_0_rd[`SIGMIX_C0_ENABLE] = state.enable;
      control_0_rd[`SIGMIX_C0_OUT] = out_level;
      control_0_rd[`SIGMIX_C0_OUTPUT_INVERT] = state.output_invert;
      control_0_rd[`SIGMIX_C0_SW_BIT] = state.sw_bit;
      control_1_rd = `SIGMIX_RST_BYTE;
      control_1_rd[`SIGMIX_C1_HIGH_INVERT] = state.high_invert;
      control_1_rd[`SIGMIX_C1_HIGH_SYNC] = state.high_sync;
      control_1_rd[`SIGMIX_C1_LOW_INVERT] = state.low_invert;
      control_1_rd[`SIGMIX_C1_LOW_SYNC] = state.low_sync;
   end

   // ***************************************************
   // next state: side tracking, register writes, read data
   // ***************************************************
   always_comb begin
      next_state = state;
      // side follows the synced modulator unless a pulse is held
      if (!holding) begin
         next_state.side = mod_s ? sigmix_pkg::SIDE_HIGH : sigmix_pkg::SIDE_LOW;
      end
      // writes; enable touches nothing but its own bit
      if (reg_wr_in) begin
         if (reg_addr_in == `SIGMIX_OFS_CONTROL_0) begin
            next_state.enable = reg_wdata_in[`SIGMIX_C0_ENABLE];
            next_state.output_invert = reg_wdata_in[`SIGMIX_C0_OUTPUT_INVERT];
            next_state.sw_bit = reg_wdata_in[`SIGMIX_C0_SW_BIT];
         end else if (reg_addr_in == `SIGMIX_OFS_CONTROL_1) begin
            next_state.high_invert = reg_wdata_in[`SIGMIX_C1_HIGH_INVERT];
            next_state.high_sync = reg_wdata_in[`SIGMIX_C1_HIGH_SYNC];
            next_state.low_invert = reg_wdata_in[`SIGMIX_C1_LOW_INVERT];
            next_state.low_sync = reg_wdata_in[`SIGMIX_C1_LOW_SYNC];
         end else if (reg_addr_in == `SIGMIX_OFS_SOURCE) begin
            next_state.mod_sel = reg_wdata_in[`SIGMIX_MOD_SEL_W-1:0];
         end else if (reg_addr_in == `SIGMIX_OFS_CARRIER_LOW) begin
            next_state.low_sel = reg_wdata_in[`SIGMIX_CAR_SEL_W-1:0];
         end else if (reg_addr_in == `SIGMIX_OFS_CARRIER_HIGH) begin
            next_state.high_sel = reg_wdata_in[`SIGMIX_CAR_SEL_W-1:0];
         end
      end
      // read data stands for exactly the cycle after the strobe
      next_state.rdata = `SIGMIX_RST_BYTE;
      if (reg_rd_in) begin
         if (reg_addr_in == `SIGMIX_OFS_CONTROL_0) begin
            next_state.rdata = control_0_rd;
         end else if (reg_addr_in == `SIGMIX_OFS_CONTROL_1) begin
            next_state.rdata = control_1_rd;
         end else if (reg_addr_in == `SIGMIX_OFS_SOURCE) begin
            next_state.rdata = {3'h0, state.mod_sel};
         end else if (reg_addr_in == `SIGMIX_OFS_CARRIER_LOW) begin
            next_state.rdata = {4'h0, state.low_sel};
         end else if (reg_addr_in == `SIGMIX_OFS_CARRIER_HIGH) begin
            next_state.rdata = {4'h0, state.high_sel};
         end
      end
   end

   // ***************************************************
   // registers
   // ***************************************************
   // reset clears enable on the same edge as every other field so the pin is low from the first edge
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state.enable <= 1'b0;
         state.output_invert <= 1'b0;
         state.sw_bit <= 1'b0;
         state.high_invert <= 1'b0;
         state.high_sync <= 1'b0;
         state.low_invert <= 1'b0;
         state.low_sync <= 1'b0;
         state.mod_sel <= `SIGMIX_RST_MOD_SEL;
         state.low_sel <= `SIGMIX_RST_CAR_SEL;
         state.high_sel <= `SIGMIX_RST_CAR_SEL;
         state.side <= sigmix_pkg::SIDE_LOW;
         state.rdata <= `SIGMIX_RST_BYTE;
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata_out = state.rdata;

endmodule : sigmix_top
